// File: rtl/cxd_core.v
// execution timing unit for control-flow and indirect-pointer instructions
// assumes a fetch stage that offers decoded instructions when ready_out is
// high and a data memory that answers mem_rdata_in within the read cycle
//
// Function
// RULE1 - pc change or true condition makes the instruction last two cycles
// RULE2 - that second cycle does nothing but let the new fetch proceed; here a return also loads pc from the popped stack entry in it
// RULE3 - indirect access through a pointer with top bit set adds one cycle
// RULE4 - pointer add adds signed literal to selected pointer, one cycle
// RULE5 - indirect load to accumulator, optional pre/post inc/dec, one cycle
// RULE6 - indirect store of accumulator, optional pre/post inc/dec, one cycle
// RULE7 - indexed indirect load reads pointer plus offset, pointer unchanged
// RULE8 - computed branch by accumulator takes two cycles
// RULE9 - call to accumulator-formed target pushes return address, two cycles
// RULE10 - return with literal loads accumulator then pops, two cycles
// RULE11 - standby entry completes in one cycle then enters standby
// RULE12 - special load copies accumulator to prescaler setup in one cycle
// RULE13 - direction load copies accumulator to selected port direction
// RULE14 - all pointer arithmetic wraps modulo sixteen bits
`timescale 1ns/100ps
`include "cxd_defines.vh"

module cxd_core (
    // clock and reset
    input  wire        clk_in,
    input  wire        rst_in,
    // instruction offer
    input  wire        instr_valid_in,
    input  wire [4:0]  instr_op_in,
    input  wire [14:0] instr_arg_in,
    input  wire        instr_sel_in,
    input  wire [1:0]  instr_mode_in,
    output reg         ready_out,
    // wake from standby
    input  wire        wake_in,
    // data memory
    output reg  [15:0] mem_addr_out,
    output reg         mem_rd_out,
    output reg         mem_wr_out,
    output reg  [7:0]  mem_wdata_out,
    input  wire [7:0]  mem_rdata_in,
    // architectural state
    output reg  [14:0] pc_out,
    output reg  [7:0]  w_out,
    output reg  [15:0] ptr0_out,
    output reg  [15:0] ptr1_out,
    output reg  [7:0]  option_out,
    output reg  [31:0] pin_dir_out,
    // system events
    output reg         standby_out,
    output reg         wdt_clear_out,
    output reg         sw_reset_out
);

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [1:0] ST_RUN   = 2'h0;
    localparam [1:0] ST_NOP   = 2'h1;
    localparam [1:0] ST_EXTRA = 2'h2;
    localparam [1:0] ST_SLEEP = 2'h3;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function [15:0] sext6;
        input [5:0] v;
        begin
            sext6 = {{10{v[5]}}, v};
        end
    endfunction

    // wraps by plain 16-bit truncation
    function [15:0] ptr_step;
        input [15:0] p;
        input [1:0]  mode;
        begin
            if (mode[0]) begin
                ptr_step = p - 16'h0001; // see RULE14
            end else begin
                ptr_step = p + 16'h0001; // see RULE14
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg [1:0]  state_r, state_nxt;
    reg [14:0] pc_r, pc_nxt;
    reg [7:0]  w_r, w_nxt;
    reg        w_pend_r, w_pend_nxt;
    reg [15:0] ptr0_r, ptr0_nxt;
    reg [15:0] ptr1_r, ptr1_nxt;
    reg [7:0]  opt_r, opt_nxt;
    reg [31:0] dir_r, dir_nxt;
    reg [3:0]  sp_r, sp_nxt;
    reg        pop_r, pop_nxt;
    reg [15:0] maddr_nxt;
    reg        mrd_nxt, mwr_nxt;
    reg [7:0]  mwdata_nxt;
    reg        wdt_nxt, swr_nxt;
    reg        stk_we, stk_re;
    reg [3:0]  stk_ra;
    reg [15:0] sel_ptr, new_ptr;
    wire [14:0] stk_rdata;
    // a load lands in the cycle after it issues; later users see it here
    wire [7:0]  w_eff = w_pend_r ? mem_rdata_in : w_r;
    wire [14:0] pc_inc = pc_r + 15'h0001;

    cxd_stack_mem u_stack (
        .clk_in      (clk_in),
        .wr_en_in    (stk_we),
        .wr_addr_in  (sp_r),
        .wr_data_in  (pc_inc),
        .rd_en_in    (stk_re),
        .rd_addr_in  (stk_ra),
        .rd_data_out (stk_rdata)
    );

    // ------------------------------------------------------------------
    // next-state decode
    // ------------------------------------------------------------------
    always @* begin
        state_nxt  = state_r;
        pc_nxt     = pc_r;
        w_nxt      = w_eff;
        w_pend_nxt = 1'b0;
        ptr0_nxt   = ptr0_r;
        ptr1_nxt   = ptr1_r;
        opt_nxt    = opt_r;
        dir_nxt    = dir_r;
        sp_nxt     = sp_r;
        pop_nxt    = 1'b0;
        maddr_nxt  = mem_addr_out;
        mrd_nxt    = 1'b0;
        mwr_nxt    = 1'b0;
        mwdata_nxt = mem_wdata_out;
        wdt_nxt    = 1'b0;
        swr_nxt    = 1'b0;
        stk_we     = 1'b0;
        stk_re     = 1'b0;
        stk_ra     = sp_r - 4'h1;
        sel_ptr    = instr_sel_in ? ptr1_r : ptr0_r;
        new_ptr    = ptr_step(sel_ptr, instr_mode_in);
        case (state_r)
            ST_RUN: begin
                if (instr_valid_in) begin
                    pc_nxt = pc_inc;
                    case (instr_op_in)
                        `CXD_OP_BRA: begin
                            pc_nxt    = pc_inc + {{6{instr_arg_in[8]}},
                                                  instr_arg_in[8:0]};
                            state_nxt = ST_NOP; // see RULE1
                        end
                        `CXD_OP_BRW: begin
                            pc_nxt    = pc_inc + {7'h00, w_eff};
                            state_nxt = ST_NOP; // see RULE8
                        end
                        `CXD_OP_CALL: begin
                            stk_we    = 1'b1;
                            sp_nxt    = sp_r + 4'h1;
                            pc_nxt    = instr_arg_in;
                            state_nxt = ST_NOP; // see RULE1
                        end
                        `CXD_OP_CALLW: begin
                            stk_we    = 1'b1; // see RULE9
                            sp_nxt    = sp_r + 4'h1;
                            pc_nxt    = {instr_arg_in[14:8], w_eff};
                            state_nxt = ST_NOP; // see RULE9
                        end
                        `CXD_OP_GOTO: begin
                            pc_nxt    = instr_arg_in;
                            state_nxt = ST_NOP; // see RULE1
                        end
                        `CXD_OP_RETURN, `CXD_OP_RETLW: begin
                            if (instr_op_in == `CXD_OP_RETLW) begin
                                w_nxt = instr_arg_in[7:0]; // see RULE10
                            end
                            stk_re    = 1'b1;
                            sp_nxt    = sp_r - 4'h1;
                            pop_nxt   = 1'b1;
                            state_nxt = ST_NOP; // see RULE10
                        end
                        `CXD_OP_SKPZ: begin
                            if (w_eff == 8'h00) begin
                                pc_nxt    = pc_r + 15'h0002;
                                state_nxt = ST_NOP; // see RULE1
                            end
                        end
                        `CXD_OP_CLRWDT:  wdt_nxt = 1'b1;
                        `CXD_OP_SWRESET: swr_nxt = 1'b1;
                        `CXD_OP_SLEEP:   state_nxt = ST_SLEEP; // see RULE11
                        `CXD_OP_OPTLD:   opt_nxt = w_eff; // see RULE12
                        `CXD_OP_DIRLD: begin
                            case (instr_arg_in[1:0]) // see RULE13
                                2'h0:    dir_nxt[7:0]   = w_eff;
                                2'h1:    dir_nxt[15:8]  = w_eff;
                                2'h2:    dir_nxt[23:16] = w_eff;
                                default: dir_nxt[31:24] = w_eff;
                            endcase
                        end
                        `CXD_OP_ADDPTR: begin
                            new_ptr = sel_ptr + sext6(instr_arg_in[5:0]);
                            if (instr_sel_in) begin
                                ptr1_nxt = new_ptr; // see RULE4
                            end else begin
                                ptr0_nxt = new_ptr; // see RULE4
                            end
                        end
                        `CXD_OP_LDIND, `CXD_OP_STIND: begin
                            // pre modes address the stepped pointer
                            maddr_nxt = instr_mode_in[1] ? sel_ptr : new_ptr;
                            if (instr_sel_in) begin
                                ptr1_nxt = new_ptr;
                            end else begin
                                ptr0_nxt = new_ptr;
                            end
                            if (instr_op_in == `CXD_OP_LDIND) begin
                                mrd_nxt    = 1'b1; // see RULE5
                                w_pend_nxt = 1'b1; // see RULE5
                            end else begin
                                mwr_nxt    = 1'b1; // see RULE6
                                mwdata_nxt = w_eff; // see RULE6
                            end
                            if (sel_ptr[`CXD_PTR_MSB]) begin
                                state_nxt = ST_EXTRA; // see RULE3
                            end
                        end
                        `CXD_OP_LDIDX: begin
                            maddr_nxt  = sel_ptr + sext6(instr_arg_in[5:0]);
                            mrd_nxt    = 1'b1; // see RULE7
                            w_pend_nxt = 1'b1; // see RULE7
                            if (sel_ptr[`CXD_PTR_MSB]) begin
                                state_nxt = ST_EXTRA; // see RULE3
                            end
                        end
                        default: ;
                    endcase
                end
            end
            ST_NOP: begin
                // idle slot; only the popped address is taken in
                if (pop_r) begin
                    pc_nxt = stk_rdata; // see RULE2
                end
                state_nxt = ST_RUN; // see RULE2
            end
            ST_EXTRA: state_nxt = ST_RUN; // see RULE3
            ST_SLEEP: begin
                if (wake_in) begin
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r       <= ST_RUN;
            pc_r          <= `CXD_PC_RST;
            w_r           <= `CXD_W_RST;
            w_pend_r      <= 1'b0;
            ptr0_r        <= `CXD_PTR_RST;
            ptr1_r        <= `CXD_PTR_RST;
            opt_r         <= `CXD_OPT_RST;
            dir_r         <= `CXD_DIR_RST;
            sp_r          <= 4'h0;
            pop_r         <= 1'b0;
            mem_addr_out  <= 16'h0000;
            mem_rd_out    <= 1'b0;
            mem_wr_out    <= 1'b0;
            mem_wdata_out <= 8'h00;
            wdt_clear_out <= 1'b0;
            sw_reset_out  <= 1'b0;
            ready_out     <= 1'b0;
            standby_out   <= 1'b0;
            pc_out        <= `CXD_PC_RST;
            w_out         <= `CXD_W_RST;
            ptr0_out      <= `CXD_PTR_RST;
            ptr1_out      <= `CXD_PTR_RST;
            option_out    <= `CXD_OPT_RST;
            pin_dir_out   <= `CXD_DIR_RST;
        end else begin
            state_r       <= state_nxt;
            pc_r          <= pc_nxt;
            w_r           <= w_nxt;
            w_pend_r      <= w_pend_nxt;
            ptr0_r        <= ptr0_nxt;
            ptr1_r        <= ptr1_nxt;
            opt_r         <= opt_nxt;
            dir_r         <= dir_nxt;
            sp_r          <= sp_nxt;
            pop_r         <= pop_nxt;
            mem_addr_out  <= maddr_nxt;
            mem_rd_out    <= mrd_nxt;
            mem_wr_out    <= mwr_nxt;
            mem_wdata_out <= mwdata_nxt;
            wdt_clear_out <= wdt_nxt;
            sw_reset_out  <= swr_nxt;
            ready_out     <= (state_nxt == ST_RUN);
            standby_out   <= (state_nxt == ST_SLEEP); // see RULE11
            // pc of a return settles in the idle slot, one edge later
            pc_out        <= pc_nxt;
            w_out         <= w_nxt;
            ptr0_out      <= ptr0_nxt;
            ptr1_out      <= ptr1_nxt;
            option_out    <= opt_nxt;
            pin_dir_out   <= dir_nxt;
        end
    end

endmodule // cxd_core

// File: rtl/cxd_defines.vh
// constants for the control-flow and indirect-pointer execution unit
// assumes inclusion by bare name from the rtl files of this block
`ifndef CXD_DEFINES_VH
`define CXD_DEFINES_VH

// ----------------------------------------------------------------------
// opcode classes presented on instr_op_in
// ----------------------------------------------------------------------
`define CXD_OP_NOP       5'h00
`define CXD_OP_BRA       5'h01
`define CXD_OP_BRW       5'h02
`define CXD_OP_CALL      5'h03
`define CXD_OP_CALLW     5'h04
`define CXD_OP_GOTO      5'h05
`define CXD_OP_RETURN    5'h06
`define CXD_OP_RETLW     5'h07
`define CXD_OP_SKPZ      5'h08
`define CXD_OP_CLRWDT    5'h09
`define CXD_OP_OPTLD     5'h0a
`define CXD_OP_SWRESET   5'h0b
`define CXD_OP_SLEEP     5'h0c
`define CXD_OP_DIRLD     5'h0d
`define CXD_OP_ADDPTR    5'h0e
`define CXD_OP_LDIND     5'h0f
`define CXD_OP_STIND     5'h10
`define CXD_OP_LDIDX     5'h11

// ----------------------------------------------------------------------
// pointer modifier codes on instr_mode_in
// ----------------------------------------------------------------------
`define CXD_MOD_PREINC   2'h0
`define CXD_MOD_PREDEC   2'h1
`define CXD_MOD_POSTINC  2'h2
`define CXD_MOD_POSTDEC  2'h3

// ----------------------------------------------------------------------
// widths, field positions and reset values
// ----------------------------------------------------------------------
`define CXD_PC_W         15
`define CXD_PTR_MSB      15
`define CXD_STK_AW       4
`define CXD_PC_RST       15'h0000
`define CXD_W_RST        8'h00
`define CXD_PTR_RST      16'h0000
`define CXD_OPT_RST      8'hff
`define CXD_DIR_RST      32'hffffffff

`endif

// File: rtl/cxd_stack_mem.v
// return-address store for the execution unit
// assumes one clock; read data appear registered the edge after rd_en
`timescale 1ns/100ps

module cxd_stack_mem (
    // clock
    input  wire        clk_in,
    // write side
    input  wire        wr_en_in,
    input  wire [3:0]  wr_addr_in,
    input  wire [14:0] wr_data_in,
    // read side
    input  wire        rd_en_in,
    input  wire [3:0]  rd_addr_in,
    output reg  [14:0] rd_data_out
);

    reg [14:0] mem_r [0:15];

    always @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
        if (rd_en_in) begin
            rd_data_out <= mem_r[rd_addr_in];
        end
    end

endmodule // cxd_stack_mem

// File: testbench/cxd_core_props.sv
// checker for the execution timing unit: stretch, pointer and copy rules
// assumes it is bound to cxd_core and sees only that module's ports
`timescale 1ns/100ps
`include "cxd_defines.vh"

module cxd_core_props (
    // clock and reset
    input wire        clk_in,
    input wire        rst_in,
    // instruction offer
    input wire        instr_valid_in,
    input wire [4:0]  instr_op_in,
    input wire [14:0] instr_arg_in,
    input wire        instr_sel_in,
    input wire [1:0]  instr_mode_in,
    input wire        ready_out,
    input wire        wake_in,
    // data memory and state
    input wire [15:0] mem_addr_out,
    input wire        mem_rd_out,
    input wire        mem_wr_out,
    input wire [7:0]  mem_wdata_out,
    input wire [7:0]  mem_rdata_in,
    input wire [7:0]  w_out,
    input wire [15:0] ptr0_out,
    input wire [15:0] ptr1_out,
    input wire [7:0]  option_out,
    input wire        standby_out
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    wire        take   = instr_valid_in && ready_out;
    wire [4:0]  op     = instr_op_in;
    wire        skip_t = op == `CXD_OP_SKPZ && w_out == 8'h00;
    wire        two_op = (op >= `CXD_OP_BRA && op <= `CXD_OP_RETLW) || skip_t;
    wire        ind_op = op == `CXD_OP_LDIND || op == `CXD_OP_STIND ||
                         op == `CXD_OP_LDIDX;
    wire [15:0] sptr   = instr_sel_in ? ptr1_out : ptr0_out;
    wire [15:0] k6     = {{10{instr_arg_in[5]}}, instr_arg_in[5:0]};
    wire        fast   = take && ind_op && !sptr[15];

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_stretch;
        !ready_out ##1 ready_out;
    endsequence
    sequence s_idle;
        !mem_rd_out && !mem_wr_out;
    endsequence

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    a_branch_stretch: assert property (take && two_op |=> s_stretch)
        else $error("two-cycle instruction not stretched by one cycle");
    a_idle_slot: assert property (take && two_op |=> s_idle)
        else $error("memory strobe in the idle slot of a stretch");
    a_ind_extra: assert property (take && ind_op && sptr[15] |=> s_stretch)
        else $error("no extra cycle for pointer with top bit set");
    a_one_cycle: assert property (
        fast || take && !skip_t && (op == `CXD_OP_ADDPTR ||
        op == `CXD_OP_OPTLD || op == `CXD_OP_DIRLD || op == `CXD_OP_SKPZ)
        |=> ready_out)
        else $error("one-cycle instruction dropped ready");
    a_addptr_sum: assert property (
        take && op == `CXD_OP_ADDPTR |=>
        ($past(instr_sel_in) ? ptr1_out : ptr0_out) == $past(sptr) + $past(k6))
        else $error("pointer add result wrong");
    a_ldind_load: assert property (fast && op == `CXD_OP_LDIND |=>
        mem_rd_out ##1 w_out == $past(mem_rdata_in))
        else $error("indirect load did not reach the accumulator");
    a_ldind_post: assert property (fast && op == `CXD_OP_LDIND &&
        instr_mode_in == `CXD_MOD_POSTINC |=> mem_addr_out == $past(sptr) &&
        ($past(instr_sel_in) ? ptr1_out : ptr0_out) == $past(sptr) + 16'h0001)
        else $error("post-increment load address or pointer wrong");
    a_stind_data: assert property (fast && op == `CXD_OP_STIND |=>
        mem_wr_out && mem_wdata_out == $past(w_out))
        else $error("indirect store data wrong");
    a_ldidx_keep: assert property (fast && op == `CXD_OP_LDIDX |=>
        mem_rd_out && mem_addr_out == $past(sptr) + $past(k6) &&
        ($past(instr_sel_in) ? ptr1_out : ptr0_out) == $past(sptr))
        else $error("indexed load address wrong or pointer moved");
    a_optld_copy: assert property (take && op == `CXD_OP_OPTLD |=>
        option_out == $past(w_out))
        else $error("prescaler setup not loaded from accumulator");
    a_standby_enter: assert property (take && op == `CXD_OP_SLEEP |=>
        standby_out && !ready_out)
        else $error("standby not entered");
    a_standby_hold: assert property (standby_out && !wake_in |=>
        standby_out && !ready_out)
        else $error("standby left without wake");
endmodule // cxd_core_props

// File: testbench/tb.sv
// self-checking bench for cxd_core: drives offers, models data memory
// assumes cxd_defines.vh on the include path and the checker file compiled
`timescale 1ns/100ps
`include "cxd_defines.vh"

module tb;
    reg         clk_in;
    reg         rst_in;
    reg         valid;
    reg  [4:0]  op;
    reg  [14:0] arg;
    reg         sel;
    reg  [1:0]  mode;
    reg         wake;
    wire        ready_out;
    wire [15:0] mem_addr_out;
    wire        mem_rd_out;
    wire        mem_wr_out;
    wire [7:0]  mem_wdata_out;
    wire [7:0]  mem_rdata_in;
    wire [14:0] pc_out;
    wire [7:0]  w_out;
    wire [15:0] ptr0_out;
    wire [15:0] ptr1_out;
    wire [7:0]  option_out;
    wire [31:0] pin_dir_out;
    wire        standby_out;
    reg  [15:0] rd_a;
    reg  [15:0] wr_a;
    reg  [7:0]  wr_d;
    reg  [1:0]  ev;
    wire [1:0]  ev_w;
    integer     cyc;
    integer     cycles;
    integer     fail_count;
    integer     tests_run;

    // memory answers combinationally so data is valid in the strobe cycle
    assign mem_rdata_in = mem_addr_out[7:0] ^ 8'h5a;

    cxd_core dut (
        .clk_in(clk_in), .rst_in(rst_in), .instr_valid_in(valid),
        .instr_op_in(op), .instr_arg_in(arg), .instr_sel_in(sel),
        .instr_mode_in(mode), .ready_out(ready_out), .wake_in(wake),
        .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
        .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out),
        .mem_rdata_in(mem_rdata_in), .pc_out(pc_out), .w_out(w_out),
        .ptr0_out(ptr0_out), .ptr1_out(ptr1_out), .option_out(option_out),
        .pin_dir_out(pin_dir_out), .standby_out(standby_out),
        .wdt_clear_out(ev_w[1]), .sw_reset_out(ev_w[0])
    );

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    always @(posedge clk_in) begin
        if (mem_rd_out === 1'b1)
            rd_a <= mem_addr_out;
        if (mem_wr_out === 1'b1) begin
            wr_a <= mem_addr_out;
            wr_d <= mem_wdata_out;
        end
        ev <= ev | ev_w;
    end

    task chk(input [31:0] g, input [31:0] e);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
            end
        end
    endtask

    // offer one instruction; cyc counts cycles until ready returns (9 = never)
    task issue(input [4:0] o, input [14:0] a, input s, input [1:0] m);
        integer n;
        begin
            @(posedge clk_in);
            valid <= 1'b1;
            op <= o;
            arg <= a;
            sel <= s;
            mode <= m;
            n = 0;
            @(posedge clk_in);
            while (ready_out !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge clk_in);
            end
            valid <= 1'b0;
            cyc = 1;
            @(posedge clk_in);
            while (ready_out !== 1'b1 && cyc < 9) begin
                cyc = cyc + 1;
                @(posedge clk_in);
            end
            @(negedge clk_in);
        end
    endtask

    task finish_test;
        begin
            $display("checks %0d, mismatches %0d", tests_run, fail_count);
            if (fail_count == 0 && tests_run > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // w is zero throughout, so the skip test is true and stretches too
    task t_cycles;
        integer i;
        begin
            for (i = 1; i < 14; i = i + 1) begin
                if (i != 12) begin
                    issue(i[4:0], 15'h0000, 1'b0, 2'h0);
                    chk(cyc, (i <= 8) ? 2 : 1);
                end
            end
            chk(ev, 2'h3);
            $display("test cycles done");
        end
    endtask

    task t_ptr;
        begin
            issue(`CXD_OP_ADDPTR, 15'h003f, 1'b0, 2'h0);
            chk(ptr0_out, 16'hffff);
            chk(cyc, 1);
            issue(`CXD_OP_LDIND, 15'h0000, 1'b0, `CXD_MOD_POSTINC);
            chk(cyc, 2);
            chk(rd_a, 16'hffff);
            chk(ptr0_out, 16'h0000);
            issue(`CXD_OP_ADDPTR, 15'h001f, 1'b1, 2'h0);
            chk(ptr1_out, 16'h001f);
            $display("test pointer add done");
        end
    endtask

    task t_ldind;
        integer m;
        reg [15:0] p;
        reg [15:0] np;
        reg [15:0] a;
        begin
            p = 16'h001f;
            for (m = 0; m < 4; m = m + 1) begin
                np = m[0] ? p - 16'h0001 : p + 16'h0001;
                a = m[1] ? p : np;
                issue(`CXD_OP_LDIND, 15'h0000, 1'b1, m[1:0]);
                chk(rd_a, a);
                chk(ptr1_out, np);
                chk(w_out, a[7:0] ^ 8'h5a);
                chk(cyc, 1);
                p = np;
            end
            issue(`CXD_OP_STIND, 15'h0000, 1'b1, `CXD_MOD_POSTDEC);
            chk(wr_a, p);
            chk(wr_d, a[7:0] ^ 8'h5a);
            chk(ptr1_out, p - 16'h0001);
            p = p - 16'h0001;
            a = p - 16'h0002;
            issue(`CXD_OP_LDIDX, 15'h003e, 1'b1, 2'h0);
            chk(rd_a, a);
            chk(ptr1_out, p);
            chk(w_out, a[7:0] ^ 8'h5a);
            $display("test indirect done");
        end
    endtask

    task t_call;
        begin
            issue(`CXD_OP_GOTO, 15'h0040, 1'b0, 2'h0);
            chk(pc_out, 15'h0040);
            issue(`CXD_OP_CALL, 15'h0123, 1'b0, 2'h0);
            issue(`CXD_OP_RETURN, 15'h0000, 1'b0, 2'h0);
            chk(pc_out, 15'h0041);
            issue(`CXD_OP_CALL, 15'h0123, 1'b0, 2'h0);
            issue(`CXD_OP_RETLW, 15'h0077, 1'b0, 2'h0);
            chk(w_out, 8'h77);
            chk(pc_out, 15'h0042);
            chk(cyc, 2);
            issue(`CXD_OP_CALLW, 15'h1200, 1'b0, 2'h0);
            chk(pc_out, 15'h1277);
            issue(`CXD_OP_RETURN, 15'h0000, 1'b0, 2'h0);
            chk(pc_out, 15'h0043);
            issue(`CXD_OP_BRW, 15'h0000, 1'b0, 2'h0);
            chk(pc_out, 15'h00bb);
            issue(`CXD_OP_SKPZ, 15'h0000, 1'b0, 2'h0);
            chk(cyc, 1);
            $display("test calls done");
        end
    endtask

    task t_copy;
        begin
            issue(`CXD_OP_OPTLD, 15'h0000, 1'b0, 2'h0);
            chk(option_out, 8'h77);
            issue(`CXD_OP_DIRLD, 15'h0002, 1'b0, 2'h0);
            chk(pin_dir_out, 32'hff77ff00);
            $display("test copies done");
        end
    endtask

    task t_sleep;
        begin
            issue(`CXD_OP_SLEEP, 15'h0000, 1'b0, 2'h0);
            chk(standby_out, 1'b1);
            chk(cyc, 9);
            @(posedge clk_in);
            valid <= 1'b1;
            op <= `CXD_OP_GOTO;
            arg <= 15'h0300;
            repeat (4) @(posedge clk_in);
            valid <= 1'b0;
            wake <= 1'b1;
            @(posedge clk_in);
            wake <= 1'b0;
            repeat (3) @(posedge clk_in);
            @(negedge clk_in);
            chk(pc_out, 15'h00bf);
            chk(standby_out, 1'b0);
            chk(ready_out, 1'b1);
            $display("test standby done");
        end
    endtask

    // ------------------------------------------------------------------
    // clock, timeout and main sequence
    // ------------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            fail_count = fail_count + 1;
            finish_test;
        end
    end

    initial begin
        rst_in = 1'b1;
        valid = 1'b0;
        op = 5'h00;
        arg = 15'h0000;
        sel = 1'b0;
        mode = 2'h0;
        wake = 1'b0;
        cycles = 0;
        fail_count = 0;
        tests_run = 0;
        ev = 2'h0;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        @(negedge clk_in);
        t_cycles;
        t_ptr;
        t_ldind;
        t_call;
        t_copy;
        t_sleep;
        finish_test;
    end
endmodule // tb

bind cxd_core cxd_core_props u_props (
    .clk_in(clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
    .instr_op_in(instr_op_in), .instr_arg_in(instr_arg_in),
    .instr_sel_in(instr_sel_in), .instr_mode_in(instr_mode_in),
    .ready_out(ready_out), .wake_in(wake_in), .mem_addr_out(mem_addr_out),
    .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
    .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in),
    .w_out(w_out), .ptr0_out(ptr0_out), .ptr1_out(ptr1_out),
    .option_out(option_out), .standby_out(standby_out)
);
